// ---- hdl/cmc_consts.svh ----
// Constants of the common mode-control block: offsets, fields, reset values, counts
`ifndef CMC_CONSTS_SVH
`define CMC_CONSTS_SVH

// ************************************************************
// Register byte addresses on the bus
// ************************************************************
`define CMC_ADR_MODE 8'h00
`define CMC_ADR_FLAGS 8'h04
`define CMC_ADR_MASK 8'h08
`define CMC_ADR_STAT 8'h0c

// ************************************************************
// Mode control fields
// ************************************************************
`define CMC_BIT_SRST 7
`define CMC_BIT_WOL 5
`define CMC_BIT_PB 4
`define CMC_BIT_PPPOE 3
`define CMC_BIT_FORCE_ARP_ENABLE 1
`define CMC_MODE_WMASK 8'h3a
`define CMC_MODE_RST 8'h00
`define CMC_MODE_SRST_RD 8'h80

// ************************************************************
// Interrupt flags and mask
// ************************************************************
`define CMC_BIT_MP 4
`define CMC_FLAG_MP 8'h10
`define CMC_FLAG_IMPL 8'h10
`define CMC_FLAG_RST 8'h00
`define CMC_MASK_RST 8'h10

// ************************************************************
// Status fields
// ************************************************************
`define CMC_BIT_BUSY 0
`define CMC_BIT_IRQ 1

// ************************************************************
// Counts
// ************************************************************
// Software reset lasts this many cycles plus one
`define CMC_SRST_LAST 4'h7
`define CMC_SYNC_LEN 3'h6
`define CMC_SYNC_BYTE 8'hff

`endif

// ---- hdl/cmc_pkg.sv ----
// Types shared by the common mode-control block
package cmc_pkg;

  typedef enum logic [1:0] {
    cmc_st_idle = 2'b01,
    cmc_st_srst = 2'b10
  } cmc_state_t;

  typedef struct packed {
    cmc_state_t state;
    logic [3:0] cnt;
    logic [7:0] mode;
    logic ack;
    logic [31:0] dat;
  } cmc_main_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] mask;
  } cmc_irq_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic ok;
    logic hit;
  } cmc_det_t;

endpackage

// ---- hdl/cmc_magic_det.sv ----
// Magic packet sync-stream detector on the received UDP payload
`include "cmc_consts.svh"

module cmc_magic_det (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic srst_i,
  input wire logic en_i,
  input wire logic rx_valid_i,
  input wire logic rx_first_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_done_i,
  output logic hit_o
);

  cmc_pkg::cmc_det_t q;
  cmc_pkg::cmc_det_t d;
  logic [2:0] cnt_n;
  logic ok_n;

  // ************************************************************
  // Sync-stream counter
  // ************************************************************
  always_comb begin
    d = q;
    d.hit = 1'b0;
    cnt_n = q.cnt;
    ok_n = q.ok;
    if (rx_valid_i) begin
      if (rx_first_i) begin
        ok_n = (rx_data_i == `CMC_SYNC_BYTE);
        cnt_n = ok_n ? 3'h1 : 3'h0;
      end else if (q.ok && q.cnt != `CMC_SYNC_LEN) begin
        if (rx_data_i == `CMC_SYNC_BYTE) begin
          cnt_n = q.cnt + 3'h1;
        end else begin
          ok_n = 1'b0;
        end
      end
    end
    d.cnt = cnt_n;
    d.ok = ok_n;
    // Only a packet that completed cleanly counts
    if (rx_done_i) begin
      d.hit = en_i && ok_n && (cnt_n == `CMC_SYNC_LEN);
      d.cnt = 3'h0;
      d.ok = 1'b0;
    end
    if (srst_i) begin
      d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hit_o = q.hit;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sync_short_miss: assert property (rx_done_i && !(ok_n && cnt_n == `CMC_SYNC_LEN) |=> !hit_o)
    else $error("magic hit without six sync bytes");

endmodule

// ---- hdl/cmc_irq.sv ----
// Sticky interrupt flags, mask and active-low interrupt pin
`include "cmc_consts.svh"

module cmc_irq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic srst_i,
  input wire logic [7:0] set_i,
  input wire logic clr_we_i,
  input wire logic msk_we_i,
  input wire logic [7:0] wdat_i,
  output logic [7:0] flags_o,
  output logic [7:0] mask_o,
  output logic irq_n_o
);

  cmc_pkg::cmc_irq_t q;
  cmc_pkg::cmc_irq_t d;
  logic [7:0] clr;

  // ************************************************************
  // Flags: write one to clear, a new event wins over the clear
  // ************************************************************
  always_comb begin
    d = q;
    clr = clr_we_i ? wdat_i : 8'h00;
    d.flags = ((q.flags & ~clr) | set_i) & `CMC_FLAG_IMPL;
    if (msk_we_i) begin
      d.mask = wdat_i & `CMC_FLAG_IMPL;
    end
    if (srst_i) begin
      d.flags = `CMC_FLAG_RST;
      d.mask = `CMC_MASK_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.flags <= `CMC_FLAG_RST;
      q.mask <= `CMC_MASK_RST;
    end else begin
      q <= d;
    end
  end

  assign flags_o = q.flags;
  assign mask_o = q.mask;
  // Pin stays low until every unmasked flag is cleared
  assign irq_n_o = ~|(q.flags & q.mask);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_flag_mp_set: assert property (set_i[`CMC_BIT_MP] && !srst_i |=> flags_o[`CMC_BIT_MP])
    else $error("magic flag not set by event");
  a_w1c_clear: assert property (clr_we_i && wdat_i[`CMC_BIT_MP] && !set_i[`CMC_BIT_MP]
                                |=> !flags_o[`CMC_BIT_MP])
    else $error("magic flag not cleared by write one");
  a_irq_level: assert property (flags_o[`CMC_BIT_MP] && mask_o[`CMC_BIT_MP] |-> !irq_n_o)
    else $error("interrupt pin high with pending flag");

endmodule

// ---- hdl/cmc_top.sv ----
// Common mode-control register bank with Wishbone slave and interrupt
// Operation
// - The mode control register is an eight-bit register at offset 0x0000 that resets to 0x00.
// - Writing one to bit 7 returns every internal register of the device to its reset value.
// - Bit 7 clears itself once the reinitialisation ends, so later reads return zero.
// - Bit 5 enables wake-on-LAN detection when one and disables it when zero.
// - With wake-on-LAN on, a correctly processed magic packet drives the interrupt pin low.
// - A magic packet counts only if its payload starts with six bytes of all ones.
// - Bit 4 one suppresses replies to incoming ping requests, zero lets them through.
// - Bit 3 switches PPPoE operation on when one and off when zero.
// - Bit 1 one forces an ARP request before every data transmission.
// - A magic packet seen with wake-on-LAN on sets bit 4 of the interrupt flags.
// - The interrupt pin stays low while a flag is set; the host clears a flag by writing one. Here the pin goes low only for a flag whose mask bit is set.
`include "cmc_consts.svh"

module cmc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Received UDP payload from the protocol engine, same clock
  input wire logic rx_valid_i,
  input wire logic rx_first_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_done_i,
  // Mode controls to the protocol engines, and the interrupt pin
  output logic wake_on_lan_enable_o,
  output logic ping_block_enable_o,
  output logic pppoe_enable_o,
  output logic force_arp_enable_o,
  output logic soft_reset_o,
  output logic interrupt_out_n_o
);

  cmc_pkg::cmc_main_t q;
  cmc_pkg::cmc_main_t d;

  logic req;
  logic wr_fire;
  logic wr_mode;
  logic srst_go;
  logic busy;
  logic [31:0] rd;
  logic magic_hit;
  logic [7:0] irq_set;
  logic [7:0] flags;
  logic [7:0] mask;
  logic irq_n;

  // ************************************************************
  // Bus decode
  // ************************************************************
  // Writes land at the edge where the master samples ack
  assign req = wb_cyc_i && wb_stb_i;
  assign busy = (q.state == cmc_pkg::cmc_st_srst);
  assign wr_fire = req && wb_we_i && q.ack && wb_sel_i[0] && !busy;
  assign wr_mode = wr_fire && (wb_adr_i == `CMC_ADR_MODE);
  assign srst_go = wr_mode && wb_dat_i[`CMC_BIT_SRST];

  always_comb begin
    case (wb_adr_i)
      `CMC_ADR_MODE: begin
        // Bit 7 reads one only while the reinitialisation runs
        rd = {24'h000000, q.mode | (busy ? `CMC_MODE_SRST_RD : 8'h00)};
      end
      `CMC_ADR_FLAGS: begin
        rd = {24'h000000, flags};
      end
      `CMC_ADR_MASK: begin
        rd = {24'h000000, mask};
      end
      `CMC_ADR_STAT: begin
        rd = {30'h00000000, ~irq_n, busy};
      end
      default: begin
        rd = 32'h00000000;
      end
    endcase
  end

  // ************************************************************
  // Mode register and software reset sequencer
  // ************************************************************
  always_comb begin
    d = q;
    d.ack = req && !q.ack;
    if (req && !q.ack) begin
      d.dat = rd;
    end
    case (q.state)
      cmc_pkg::cmc_st_idle: begin
        if (srst_go) begin
          d.state = cmc_pkg::cmc_st_srst;
          d.cnt = `CMC_SRST_LAST;
          d.mode = `CMC_MODE_RST;
        end else if (wr_mode) begin
          // Reserved positions are masked off on the way in
          d.mode = wb_dat_i[7:0] & `CMC_MODE_WMASK;
        end
      end
      cmc_pkg::cmc_st_srst: begin
        d.mode = `CMC_MODE_RST;
        if (q.cnt == 4'h0) begin
          d.state = cmc_pkg::cmc_st_idle;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      default: begin
        d.state = cmc_pkg::cmc_st_idle;
        d.cnt = 4'h0;
        d.mode = `CMC_MODE_RST;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.state <= cmc_pkg::cmc_st_idle;
      q.cnt <= 4'h0;
      q.mode <= `CMC_MODE_RST;
      q.ack <= 1'b0;
      q.dat <= 32'h00000000;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // Magic packet detection and interrupt
  // ************************************************************
  cmc_magic_det u_det (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .srst_i(busy),
    .en_i(q.mode[`CMC_BIT_WOL]),
    .rx_valid_i(rx_valid_i),
    .rx_first_i(rx_first_i),
    .rx_data_i(rx_data_i),
    .rx_done_i(rx_done_i),
    .hit_o(magic_hit)
  );

  assign irq_set = magic_hit ? `CMC_FLAG_MP : 8'h00;

  cmc_irq u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .srst_i(busy),
    .set_i(irq_set),
    .clr_we_i(wr_fire && (wb_adr_i == `CMC_ADR_FLAGS)),
    .msk_we_i(wr_fire && (wb_adr_i == `CMC_ADR_MASK)),
    .wdat_i(wb_dat_i[7:0]),
    .flags_o(flags),
    .mask_o(mask),
    .irq_n_o(irq_n)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign wake_on_lan_enable_o = q.mode[`CMC_BIT_WOL];
  assign ping_block_enable_o = q.mode[`CMC_BIT_PB];
  assign pppoe_enable_o = q.mode[`CMC_BIT_PPPOE];
  assign force_arp_enable_o = q.mode[`CMC_BIT_FORCE_ARP_ENABLE];
  // Engines elsewhere reinitialise while this is high
  assign soft_reset_o = busy;
  assign interrupt_out_n_o = irq_n;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_mode_reset_val: assert property (disable iff (1'b0) $past(rst_i) |-> q.mode == 8'h00)
    else $error("mode not zero after reset");
  a_srst_pulse: assert property (srst_go |=> soft_reset_o [*8] ##1 !soft_reset_o)
    else $error("software reset length wrong");
  a_srst_self_clr: assert property ($fell(soft_reset_o) |-> q.mode == 8'h00 && flags == 8'h00
                                    && mask == `CMC_MASK_RST)
    else $error("registers not initialised after software reset");
  a_wol_gate: assert property (magic_hit |-> $past(wake_on_lan_enable_o))
    else $error("magic hit while wake-on-LAN off");
  a_magic_irq: assert property (magic_hit && mask[`CMC_BIT_MP] && !busy && !srst_go
                                |=> !interrupt_out_n_o)
    else $error("interrupt pin not low after magic packet");
  a_ping_write: assert property (wr_mode && !srst_go
                                 |=> ping_block_enable_o == $past(wb_dat_i[`CMC_BIT_PB]))
    else $error("ping block not written");
  a_pppoe_write: assert property (wr_mode && !srst_go
                                  |=> pppoe_enable_o == $past(wb_dat_i[`CMC_BIT_PPPOE]))
    else $error("pppoe enable not written");
  a_force_arp_enable_write: assert property (wr_mode && !srst_go
                                 |=> force_arp_enable_o == $past(wb_dat_i[`CMC_BIT_FORCE_ARP_ENABLE]))
    else $error("force arp not written");
  a_rsvd_zero: assert property (q.ack && $past(wb_adr_i) == `CMC_ADR_MODE && !$past(wb_we_i)
                                |-> wb_dat_o[6] == 1'b0 && wb_dat_o[2] == 1'b0
                                && wb_dat_o[0] == 1'b0)
    else $error("reserved mode bit read as one");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_srst_done: cover property (srst_go ##[1:20] $fell(soft_reset_o));
  c_magic_irq: cover property (magic_hit ##1 !interrupt_out_n_o);
  c_flag_clear: cover property (!interrupt_out_n_o ##[1:50] interrupt_out_n_o);
  c_mode_write: cover property (wr_mode && wb_dat_i[`CMC_BIT_WOL]);

endmodule

// ---- verif/cmc_rx_src.sv ----
// Payload source standing in for the receive path of the protocol engine
module cmc_rx_src (
  input wire logic clk_i,
  output logic rx_valid_o,
  output logic rx_first_o,
  output logic [7:0] rx_data_o,
  output logic rx_done_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    rx_valid_o = 1'b0;
    rx_first_o = 1'b0;
    rx_data_o = 8'h5a;
    rx_done_o = 1'b0;
  end

  // ************************************************************
  // Packet sender: n bytes, byte number bad carries 0xfe, then done
  // ************************************************************
  task automatic send(input int n, input int bad);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_first_o <= (i == 0);
      rx_data_o <= (i == bad) ? 8'hfe : 8'hff;
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_first_o <= 1'b0;
    // Idle data toggles so a stale sync byte never looks valid
    rx_data_o <= ~rx_data_o;
    rx_done_o <= 1'b1;
    @(posedge clk_i);
    rx_done_o <= 1'b0;
  endtask
endmodule

// ---- verif/common_mode_control_test.sv ----
// Self-checking bench for the common mode-control register bank
`include "cmc_consts.svh"
module common_mode_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, rx_data;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic rx_valid, rx_first, rx_done, wake_on_lan_enable, pb, pppoe, force_arp_enable, srst, irq_n;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;

  always #20 clk_i = ~clk_i;

  cmc_top i_cmc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid), .rx_first_i(rx_first),
    .rx_data_i(rx_data), .rx_done_i(rx_done), .wake_on_lan_enable_o(wake_on_lan_enable),
    .ping_block_enable_o(pb), .pppoe_enable_o(pppoe), .force_arp_enable_o(force_arp_enable),
    .soft_reset_o(srst), .interrupt_out_n_o(irq_n));

  cmc_rx_src i_cmc_rx_src (.clk_i(clk_i), .rx_valid_o(rx_valid), .rx_first_o(rx_first),
    .rx_data_o(rx_data), .rx_done_o(rx_done));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle, entered at a rising edge; returns one idle edge after ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
      input logic [3:0] sel);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    chk({31'h0, wb_ack_o}, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    wb(1'b1, adr, d, 4'h1);
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00, 4'h1);
    chk(rd, {24'h0, exp});
  endtask

  task automatic pkt(input int n, input int bad);
    i_cmc_rx_src.send(n, bad);
    repeat (4) @(posedge clk_i);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    rdchk(`CMC_ADR_MODE, 8'h00);
    rdchk(`CMC_ADR_FLAGS, 8'h00);
    rdchk(8'h20, 8'h00);
    chk({31'h0, irq_n}, 32'h1);
  endtask

  task automatic t_mode_bits;
    logic [7:0] pat [4] = '{8'h20, 8'h10, 8'h08, 8'h02};
    for (int i = 0; i < 4; i++) begin
      wr(`CMC_ADR_MODE, pat[i]);
      chk({28'h0, wake_on_lan_enable, pb, pppoe, force_arp_enable}, 32'h8 >> i);
    end
    wr(`CMC_ADR_MODE, 8'h7f);
    rdchk(`CMC_ADR_MODE, 8'h3a);
    // Writes without the low byte lane enabled are dropped
    wb(1'b1, `CMC_ADR_MODE, 8'h00, 4'he);
    rdchk(`CMC_ADR_MODE, 8'h3a);
    wr(`CMC_ADR_MODE, 8'h00);
  endtask

  task automatic t_magic;
    pkt(6, -1);
    rdchk(`CMC_ADR_FLAGS, 8'h00);
    // Host has its UDP socket open before turning detection on
    wr(`CMC_ADR_MODE, 8'h20);
    pkt(6, 3);
    rdchk(`CMC_ADR_FLAGS, 8'h00);
    pkt(5, -1);
    rdchk(`CMC_ADR_FLAGS, 8'h00);
    pkt(7, 6);
    chk({31'h0, irq_n}, 32'h0);
    rdchk(`CMC_ADR_FLAGS, 8'h10);
    wr(`CMC_ADR_FLAGS, 8'h10);
    @(posedge clk_i);
    chk({31'h0, irq_n}, 32'h1);
    rdchk(`CMC_ADR_FLAGS, 8'h00);
  endtask

  task automatic t_mask;
    wr(`CMC_ADR_MASK, 8'h00);
    pkt(6, -1);
    chk({31'h0, irq_n}, 32'h1);
    rdchk(`CMC_ADR_FLAGS, 8'h10);
    wr(`CMC_ADR_MASK, 8'h10);
    @(posedge clk_i);
    chk({31'h0, irq_n}, 32'h0);
    rdchk(`CMC_ADR_STAT, 8'h02);
  endtask

  task automatic t_soft_reset;
    int k;
    k = 0;
    wr(`CMC_ADR_MODE, 8'h3a);
    wr(`CMC_ADR_MASK, 8'h00);
    wr(`CMC_ADR_MODE, 8'hba);
    @(posedge clk_i);
    chk({31'h0, srst}, 32'h1);
    // Both reads are answered well inside the eight busy cycles
    rdchk(`CMC_ADR_MODE, 8'h80);
    rdchk(`CMC_ADR_STAT, 8'h01);
    while (srst === 1'b1 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    chk({28'h0, wake_on_lan_enable, pb, pppoe, force_arp_enable}, 32'h0);
    rdchk(`CMC_ADR_MODE, 8'h00);
    rdchk(`CMC_ADR_FLAGS, 8'h00);
    rdchk(`CMC_ADR_MASK, 8'h10);
    chk({31'h0, irq_n}, 32'h1);
  endtask

  // ************************************************************
  // Verdict, timeout and main sequence
  // ************************************************************
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run needs well under two thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_mode_bits();
    t_magic();
    t_mask();
    t_soft_reset();
    tally_and_finish();
  end
endmodule
